// ===== verilog/tmc_pkg.sv
/*
  Constants, types and register map of the terminal mode controller.
  Assumes a single 20 MHz clock and a plain strobe register port.

// Function
// RQ1: Terminal is always in compose or receive mode; transmit and print are transient.
// RQ2: Compose button selects compose mode; line data refused, keyboard and transmit allowed.
// RQ3: Compose mode shows L as mode symbol.
// RQ4: Host message to a compose-mode terminal triggers an automatic busy reply.
// RQ5: Receive button selects receive mode, shows R, enables sending and receiving.
// RQ6: Receive mode allows typing when idle; host message may interrupt typing.
// RQ7: Keyboard blocked while a message moves, except automatic acknowledgments.
// RQ8: Received characters load at the entry marker and advance it; host may place it.
// RQ9: Host ends messages with ETX; received ETX never moves the end-of-text symbol.
// RQ10: End-of-text symbol C always shown in right margin of exactly one line.
// RQ11: Line error while receiving blinks mode symbol until clean message; ignored if busy.
// RQ12: End-of-text key moves the symbol to the entry marker's line.
// RQ13: Transmit sends page order from entry marker through end-of-text line.
// RQ14: Transmit button shows T at once.
// RQ15: Host acknowledgment of transmit erases T, shows R, enters receive mode.
// RQ16: Compose selected while acknowledgment pending stays compose; later ack keeps it.
// RQ17: Carriage return and line feed inserted after every sent line except the last.
// RQ18: Keyboard rejected from transmit press until transmission ends.
// RQ19: After transmission, entry marker goes to column 0 of line after end-of-text.
// RQ20: Print button sends like transmit, blocks keyboard, shows P.
// RQ21: Print acknowledgment erases P, shows R, enters receive mode, frees terminal.
// RQ22: Negative acknowledgments are ignored once compose was selected before the ack.
// RQ23: Mode symbol drawn in the cell before the first text position of line 0.
// RQ24: Each text line holds 46 character positions.
// RQ25: Pending acknowledgment waits forever unless a timeout is configured.
*/
package tmc_pkg;
  localparam int          COLS      = 46;
  localparam int          ROWS_MAX  = 26;
  localparam int          CELLS     = COLS * ROWS_MAX;
  localparam logic [5:0]  COL_LAST  = 6'h2D;
  localparam logic [5:0]  COL_RIGHT = 6'h2F;
  localparam logic [6:0]  SYM_LOCAL = 7'h4C;
  localparam logic [6:0]  SYM_RECV  = 7'h52;
  localparam logic [6:0]  SYM_TX    = 7'h54;
  localparam logic [6:0]  SYM_PRINT = 7'h50;
  localparam logic [6:0]  SYM_ETX   = 7'h43;
  localparam logic [6:0]  CODE_SP   = 7'h20;
  localparam logic [6:0]  CODE_CR   = 7'h0D;
  localparam logic [6:0]  CODE_LF   = 7'h0A;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_TIMEOUT = 8'h04;
  localparam logic [7:0]  REG_STATUS  = 8'h08;
  localparam logic [7:0]  REG_POS     = 8'h0C;
  localparam logic [4:0]  LINES_RST   = 5'h1A;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
  localparam int          ST_SYM_LSB  = 8;
  localparam int          POS_ROW_LSB = 8;
  localparam int          POS_ETX_LSB = 16;

  typedef enum logic [1:0] {
    MODE_COMPOSE = 2'b01,
    MODE_RECEIVE = 2'b10
  } tmc_mode_e;

  typedef enum logic [5:0] {
    ACT_IDLE   = 6'b000001,
    ACT_RECV   = 6'b000010,
    ACT_TXSEND = 6'b000100,
    ACT_TXWAIT = 6'b001000,
    ACT_PRSEND = 6'b010000,
    ACT_PRWAIT = 6'b100000
  } tmc_act_e;

  typedef struct packed {
    logic [4:0] row;
    logic [5:0] col;
  } tmc_pos_s;

  typedef struct packed {
    logic       start;
    logic       charValid;
    logic [6:0] charCode;
    logic       etx;
    logic       ack;
    logic       nak;
    logic       lineError;
    logic       markerLoad;
    tmc_pos_s   marker;
  } tmc_rx_s;
endpackage

// ===== verilog/tmc_terminal_mode_controller.sv
/*
  Mode and message-flow controller for one keyboard/display terminal:
  page store, entry marker, end-of-text line, transmit/print sequencing.
  Assumes decoded host messages arrive as one-cycle pulses and buttons
  and keys are one-cycle pulses, all synchronous to clock.
*/
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module tmc_terminal_mode_controller (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            composeModeButton,
  input  wire logic            receiveModeButton,
  input  wire logic            transmitButton,
  input  wire logic            hardcopyButton,
  input  wire logic            etxKey,
  input  wire logic            keyValid,
  input  wire logic [6:0]      keyChar,
  input  wire tmc_pkg::tmc_rx_s rxMsg,
  output logic                 busyReply,
  output logic                 txValid,
  output logic [6:0]           txChar,
  output logic                 txIsPrint,
  input  wire logic            txReady,
  output logic                 keyboardEnable,
  output logic [6:0]           modeSymbol,
  output logic                 modeBlink,
  input  wire logic [4:0]      dispRow,
  input  wire logic [5:0]      dispCol,
  output logic [6:0]           dispChar,
  output logic                 dispBlink,
  input  wire logic [7:0]      regAddr,
  input  wire logic [31:0]     regWdata,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  output logic [31:0]          regRdata
);
  import tmc_pkg::*;

  tmc_mode_e   mode_r;
  tmc_act_e    act_r;
  logic        override_r;
  logic        blink_r;
  logic        msgErr_r;
  tmc_pos_s    marker_r;
  tmc_pos_s    txPos_r;
  tmc_pos_s    txStart_r;
  logic [4:0]  etxLine_r;
  logic [1:0]  phase_r;
  logic [4:0]  lines_r;
  logic [31:0] timeout_r;
  logic [31:0] waitCnt_r;
  logic        txValid_r;
  logic [6:0]  txChar_r;
  logic        busy_r;
  logic [6:0]  sym_r;
  logic [6:0]  dispChar_r;
  logic        dispBlink_r;
  logic [31:0] rdata_r;
  logic [6:0]  page [CELLS];

  logic        sending, waiting, slotFree, lastCell, sendDone;
  logic        timedOut, kbdOk, goSend, goPrint, rxTaken;

  function automatic logic [10:0] cellIdx(input logic [4:0] row, input logic [5:0] col);
    logic [10:0] base;
    base = 11'(row) * 11'(COLS);
    return base + 11'(col);
  endfunction

  function automatic logic [4:0] rowAfter(input logic [4:0] row, input logic [4:0] lines);
    return (row >= lines - 5'h01) ? 5'h00 : row + 5'h01;
  endfunction

  // Line length bounds every sequential walk [RQ24]
  function automatic tmc_pos_s advance(input tmc_pos_s p, input logic [4:0] lines);
    tmc_pos_s n;
    n = p;
    if (p.col == COL_LAST) begin
      n.col = 6'h00;
      n.row = rowAfter(p.row, lines);
    end else begin
      n.col = p.col + 6'h01;
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Activity decode
  assign sending  = (act_r == ACT_TXSEND) || (act_r == ACT_PRSEND);
  assign waiting  = (act_r == ACT_TXWAIT) || (act_r == ACT_PRWAIT);
  assign slotFree = !txValid_r || txReady;
  assign lastCell = (phase_r == 2'd0) && (txPos_r.col == COL_LAST)
                    && (txPos_r.row == etxLine_r);
  assign sendDone = sending && slotFree && lastCell;
  // Zero timeout means wait for the host forever [RQ25]
  assign timedOut = waiting && (timeout_r != 32'h0000_0000) && (waitCnt_r >= timeout_r);
  // Only an idle terminal takes keys; acks never leave idle [RQ7] [RQ18] [RQ6]
  assign kbdOk    = (act_r == ACT_IDLE);
  assign goSend   = kbdOk && transmitButton;
  assign goPrint  = kbdOk && hardcopyButton && !transmitButton;
  // Host data only lands on an idle terminal in receive mode [RQ2] [RQ6]
  assign rxTaken  = rxMsg.start && (mode_r == MODE_RECEIVE) && (act_r == ACT_IDLE)
                    && !composeModeButton && !goSend && !goPrint;

  ////////////////////////////////////////////////////////////////////////////
  // Mode and activity
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_r     <= MODE_RECEIVE;
      act_r      <= ACT_IDLE;
      override_r <= 1'b0;
    end else begin
      unique case (act_r)
        ACT_IDLE: begin
          if (rxTaken) begin
            act_r <= ACT_RECV;
          end else if (goSend) begin
            act_r      <= ACT_TXSEND;
            override_r <= 1'b0;
          end else if (goPrint) begin
            act_r      <= ACT_PRSEND;
            override_r <= 1'b0;
          end
        end
        ACT_RECV: begin
          if (rxMsg.etx) begin
            act_r <= ACT_IDLE;
          end
        end
        ACT_TXSEND, ACT_PRSEND: begin
          if (sendDone) begin
            act_r <= (act_r == ACT_TXSEND) ? ACT_TXWAIT : ACT_PRWAIT;
          end
        end
        ACT_TXWAIT, ACT_PRWAIT: begin
          if (rxMsg.ack || timedOut) begin
            act_r      <= ACT_IDLE;
            override_r <= 1'b0;
            // Ack returns to receive unless compose was chosen [RQ15] [RQ21] [RQ16]
            if (!override_r) begin
              mode_r <= MODE_RECEIVE;
            end
          end else if (rxMsg.nak && !override_r) begin
            // Resend after a refusal; dropped once operator left [RQ22]
            act_r <= (act_r == ACT_TXWAIT) ? ACT_TXSEND : ACT_PRSEND;
          end
        end
      endcase
      // Exactly two steady modes, chosen by the buttons [RQ1] [RQ2] [RQ5]
      if (composeModeButton) begin
        mode_r <= MODE_COMPOSE;
        if (sending || waiting) begin
          override_r <= 1'b1;
        end
        if (act_r == ACT_RECV) begin
          act_r <= ACT_IDLE;
        end
      end else if (receiveModeButton) begin
        mode_r     <= MODE_RECEIVE;
        override_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Busy answer to host messages that cannot be taken
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= rxMsg.start && !rxTaken; // [RQ4]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line error indication
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      blink_r  <= 1'b0;
      msgErr_r <= 1'b0;
    end else begin
      if (rxTaken) begin
        msgErr_r <= 1'b0;
      end
      // Errors outside a reception are the busy case and are ignored [RQ11]
      if (act_r == ACT_RECV) begin
        if (rxMsg.lineError) begin
          blink_r  <= 1'b1;
          msgErr_r <= 1'b1;
        end else if (rxMsg.etx && !msgErr_r) begin
          blink_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry marker and end-of-text line
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      marker_r  <= '0;
      etxLine_r <= 5'h00;
    end else begin
      if (kbdOk && keyValid) begin
        marker_r <= advance(marker_r, lines_r);
      end
      if (kbdOk && etxKey) begin
        etxLine_r <= marker_r.row; // [RQ12] [RQ10]
      end
      // Host may place the marker; each character steps it [RQ8]
      if (act_r == ACT_RECV) begin
        if (rxMsg.markerLoad) begin
          marker_r <= rxMsg.marker;
        end else if (rxMsg.charValid) begin
          marker_r <= advance(marker_r, lines_r);
        end
      end
      if (sendDone && act_r == ACT_TXSEND) begin
        marker_r.row <= rowAfter(etxLine_r, lines_r); // [RQ19]
        marker_r.col <= 6'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page store; received ETX is not a character and is not stored [RQ9]
  always_ff @(posedge clock) begin
    if (kbdOk && keyValid) begin
      page[cellIdx(marker_r.row, marker_r.col)] <= keyChar;
    end else if (act_r == ACT_RECV && rxMsg.charValid && !rxMsg.markerLoad) begin
      page[cellIdx(marker_r.row, marker_r.col)] <= rxMsg.charCode; // [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and print sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txPos_r   <= '0;
      txStart_r <= '0;
      phase_r   <= 2'd0;
      txValid_r <= 1'b0;
      txChar_r  <= 7'h00;
    end else begin
      if (txReady) begin
        txValid_r <= 1'b0;
      end
      if (goSend || goPrint) begin
        txPos_r   <= marker_r;
        txStart_r <= marker_r;
        phase_r   <= 2'd0;
      end else if (waiting && rxMsg.nak && !override_r && !rxMsg.ack && !timedOut) begin
        txPos_r <= txStart_r;
        phase_r <= 2'd0;
      end else if (sending && slotFree) begin
        txValid_r <= 1'b1;
        unique case (phase_r)
          2'd1: begin
            txChar_r <= CODE_CR; // [RQ17]
            phase_r  <= 2'd2;
          end
          2'd2: begin
            txChar_r    <= CODE_LF; // [RQ17]
            phase_r     <= 2'd0;
            txPos_r.row <= rowAfter(txPos_r.row, lines_r);
            txPos_r.col <= 6'h00;
          end
          default: begin
            // Page order from the marker up to the end-of-text line [RQ13]
            txChar_r <= page[cellIdx(txPos_r.row, txPos_r.col)];
            if (txPos_r.col == COL_LAST) begin
              if (txPos_r.row != etxLine_r) begin
                phase_r <= 2'd1; // [RQ17]
              end
            end else begin
              txPos_r.col <= txPos_r.col + 6'h01;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      waitCnt_r <= 32'h0000_0000;
    end else begin
      waitCnt_r <= waiting ? waitCnt_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode symbol and display cells
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sym_r <= SYM_RECV;
    end else if (composeModeButton) begin
      sym_r <= SYM_LOCAL; // [RQ3] [RQ16]
    end else if (goSend) begin
      sym_r <= SYM_TX; // [RQ14]
    end else if (goPrint) begin
      sym_r <= SYM_PRINT; // [RQ20]
    end else if (receiveModeButton && !sending && !waiting) begin
      sym_r <= SYM_RECV; // [RQ5]
    end else if (receiveModeButton) begin
      sym_r <= (act_r == ACT_TXSEND || act_r == ACT_TXWAIT) ? SYM_TX : SYM_PRINT;
    end else if (waiting && (rxMsg.ack || timedOut)) begin
      sym_r <= override_r ? SYM_LOCAL : SYM_RECV; // [RQ15] [RQ21] [RQ16]
    end
  end

  // Column 0 is the margin cell before text, 47 the right margin
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dispChar_r  <= CODE_SP;
      dispBlink_r <= 1'b0;
    end else begin
      dispBlink_r <= 1'b0;
      if (dispCol == 6'h00) begin
        dispChar_r  <= (dispRow == 5'h00) ? sym_r : CODE_SP; // [RQ23]
        dispBlink_r <= (dispRow == 5'h00) && blink_r; // [RQ11]
      end else if (dispCol == COL_RIGHT) begin
        dispChar_r <= (dispRow == etxLine_r) ? SYM_ETX : CODE_SP; // [RQ10]
      end else if (dispCol < COL_RIGHT) begin
        dispChar_r <= page[cellIdx(dispRow, dispCol - 6'h01)];
      end else begin
        dispChar_r <= CODE_SP;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      lines_r   <= LINES_RST;
      timeout_r <= TIMEOUT_RST;
    end else if (regWrite) begin
      if (regAddr == REG_CTRL) begin
        // Fewer lines than four or more than the page holds are refused
        if (regWdata[4:0] >= 5'h04 && regWdata[4:0] <= LINES_RST) begin
          lines_r <= regWdata[4:0];
        end
      end else if (regAddr == REG_TIMEOUT) begin
        timeout_r <= regWdata;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (regRead) begin
        unique case (regAddr)
          REG_CTRL:    rdata_r <= {27'h0, lines_r};
          REG_TIMEOUT: rdata_r <= timeout_r;
          REG_STATUS: begin
            rdata_r[1:0] <= mode_r;
            rdata_r[2]   <= sending;
            rdata_r[3]   <= waiting;
            rdata_r[4]   <= (act_r == ACT_PRSEND) || (act_r == ACT_PRWAIT);
            rdata_r[5]   <= (act_r == ACT_RECV);
            rdata_r[6]   <= blink_r;
            rdata_r[7]   <= kbdOk;
            rdata_r[ST_SYM_LSB +: 7] <= sym_r;
          end
          REG_POS: begin
            rdata_r[5:0]              <= marker_r.col;
            rdata_r[POS_ROW_LSB +: 5] <= marker_r.row;
            rdata_r[POS_ETX_LSB +: 5] <= etxLine_r;
          end
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign busyReply      = busy_r;
  assign txValid        = txValid_r;
  assign txChar         = txChar_r;
  assign txIsPrint      = (act_r == ACT_PRSEND);
  assign keyboardEnable = kbdOk;
  assign modeSymbol     = sym_r;
  assign modeBlink      = blink_r;
  assign dispChar       = dispChar_r;
  assign dispBlink      = dispBlink_r;
  assign regRdata       = rdata_r;
endmodule

// ===== dv/tmc_checker_assertions.sv
/* Port checker of the terminal mode controller.
   Assumes it is bound onto tmc_terminal_mode_controller, one clock domain. */
`timescale 1ns/1ps
module tmc_checker
  import tmc_pkg::*;
(
  input wire logic             clock,
  input wire logic             reset,
  input wire logic             composeModeButton,
  input wire logic             receiveModeButton,
  input wire logic             transmitButton,
  input wire logic             hardcopyButton,
  input wire tmc_pkg::tmc_rx_s rxMsg,
  input wire logic             busyReply,
  input wire logic             txValid,
  input wire logic [6:0]       txChar,
  input wire logic             txReady,
  input wire logic             keyboardEnable,
  input wire logic [6:0]       modeSymbol,
  input wire logic             modeBlink
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  a_compose_shows_l: assert property (
    composeModeButton && keyboardEnable |=> modeSymbol == SYM_LOCAL)
    else $error("compose button did not show L");
  a_receive_shows_r: assert property (
    receiveModeButton && !composeModeButton && !transmitButton && !hardcopyButton
      && keyboardEnable |=> modeSymbol == SYM_RECV)
    else $error("receive button did not show R");
  a_transmit_shows_t: assert property (
    transmitButton && !composeModeButton && keyboardEnable
      |=> modeSymbol == SYM_TX && !keyboardEnable)
    else $error("transmit did not show T and lock keys");
  a_print_shows_p: assert property (
    hardcopyButton && !transmitButton && !composeModeButton && keyboardEnable
      |=> modeSymbol == SYM_PRINT && !keyboardEnable)
    else $error("print did not show P and lock keys");
  a_busy_in_compose: assert property (
    rxMsg.start && modeSymbol == SYM_LOCAL && keyboardEnable |=> busyReply)
    else $error("no busy reply in compose mode");
  a_busy_has_cause: assert property (
    busyReply |-> $past(rxMsg.start))
    else $error("busy reply without host message");
  a_tx_char_holds: assert property (
    txValid && !txReady |=> txValid && $stable(txChar))
    else $error("tx char dropped before acceptance");
  a_keys_locked_tx: assert property (
    txValid |-> !keyboardEnable)
    else $error("keyboard open while sending");
  a_error_blinks: assert property (
    rxMsg.lineError && modeSymbol == SYM_RECV && !keyboardEnable && !txValid
      && !composeModeButton |=> modeBlink)
    else $error("line error did not blink");
  a_ack_keeps_local: assert property (
    rxMsg.ack && modeSymbol == SYM_LOCAL && !receiveModeButton |=> modeSymbol == SYM_LOCAL)
    else $error("ack left compose mode");
  c_transmit: cover property (transmitButton && keyboardEnable);
  c_busy: cover property (busyReply);
  c_line_feed: cover property (txValid && txReady && txChar == CODE_LF);
endmodule

bind tmc_terminal_mode_controller tmc_checker tmc_checker_inst (
  .clock, .reset, .composeModeButton, .receiveModeButton, .transmitButton,
  .hardcopyButton, .rxMsg, .busyReply, .txValid, .txChar, .txReady,
  .keyboardEnable, .modeSymbol, .modeBlink
);

// ===== dv/tmc_host_model.sv
/* Host side of the transmit stream: accepts characters and keeps the first four.
   Assumes txValid holds until accepted; slow makes it stall every other cycle. */
`timescale 1ns/1ps
module tmc_host_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        txValid,
  input  wire logic [6:0]  txChar,
  input  wire logic        slow,
  output logic             txReady,
  output logic [7:0]       count,
  output logic [27:0]      head
);
  // Stalling half the time checks that the sender holds its character
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txReady <= 1'b0;
      count   <= 8'h00;
      head    <= 28'h0000000;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      if (txValid && txReady) begin
        count <= count + 8'h01;
        if (count < 8'h04) head <= {head[20:0], txChar};
      end
    end
  end
endmodule

// ===== dv/tb_top.sv
/* Self-checking testbench of the terminal mode controller.
   Assumes the package, host model and checker are compiled before it. */
`timescale 1ns/1ps
module tb_top;
  import tmc_pkg::*;
  typedef struct packed {logic [5:0] b; logic [6:0] s;} tmc_row_s;
  // Host message words: start, char, etx, ack, nak, error, marker load
  localparam logic [24:0] F_ST  = 25'h1000000;
  localparam logic [24:0] F_ETX = 25'h0008000;
  localparam logic [24:0] F_ACK = 25'h0004000;
  localparam logic [24:0] F_NAK = 25'h0002000;
  localparam logic [24:0] F_ERR = 25'h0001000;
  localparam logic [24:0] F_LD  = 25'h0000800;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [5:0]  btn = 6'h00;
  tmc_rx_s     rx = '0;
  logic [4:0]  dispRow = 5'h00;
  logic [5:0]  dispCol = 6'h00;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        slow = 1'b1;
  logic        busyReply, txValid, txIsPrint, txReady, keyboardEnable, modeBlink, dispBlink;
  logic [6:0]  txChar, modeSymbol, dispChar;
  logic [31:0] regRdata;
  logic [7:0]  count;
  logic [27:0] head;
  int          errCount = 0;
  int          numChecks = 0;
  tmc_row_s    rows [5] = '{'{6'h10, SYM_LOCAL}, '{6'h08, SYM_RECV}, '{6'h10, SYM_LOCAL},
                            '{6'h18, SYM_LOCAL}, '{6'h08, SYM_RECV}};
  always #25 clock = ~clock;
  tmc_terminal_mode_controller tmc_terminal_mode_controller_inst (
    .clock(clock), .reset(reset), .composeModeButton(btn[4]), .receiveModeButton(btn[3]),
    .transmitButton(btn[2]), .hardcopyButton(btn[1]), .etxKey(btn[0]), .keyValid(btn[5]),
    .keyChar(7'h5A), .rxMsg(rx), .busyReply(busyReply), .txValid(txValid), .txChar(txChar),
    .txIsPrint(txIsPrint), .txReady(txReady), .keyboardEnable(keyboardEnable),
    .modeSymbol(modeSymbol), .modeBlink(modeBlink), .dispRow(dispRow), .dispCol(dispCol),
    .dispChar(dispChar), .dispBlink(dispBlink), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
  tmc_host_model tmc_host_model_inst (
    .clock(clock), .reset(reset), .txValid(txValid), .txChar(txChar), .slow(slow),
    .txReady(txReady), .count(count), .head(head));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrapUp();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic push(input logic [5:0] b);
    @(posedge clock);
    btn <= b;
    @(posedge clock);
    btn <= 6'h00;
    #1;
  endtask
  task automatic host(input logic [24:0] v);
    @(posedge clock);
    rx <= tmc_rx_s'(v);
    @(posedge clock);
    rx <= '0;
    #1;
  endtask
  // Host places the marker and ends the message with ETX
  task automatic hostMsg(input logic [10:0] pos, input logic [24:0] extra);
    host(F_ST);
    host(F_LD | {14'h0, pos});
    if (extra != 25'h0) host(extra);
    host(F_ETX);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic disp(input logic [4:0] r, input logic [5:0] c, input logic [6:0] exp);
    @(posedge clock);
    dispRow <= r;
    dispCol <= c;
    @(posedge clock);
    #1;
    check({25'h0, dispChar}, {25'h0, exp});
  endtask
  task automatic waitTx(input logic [7:0] n);
    int i;
    for (i = 0; i < 600 && (count != n || txValid !== 1'b0); i++) @(posedge clock);
    #1;
    if (i == 600) begin
      errCount++;
      wrapUp();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    #1;
    check({25'h0, modeSymbol}, {25'h0, SYM_RECV});
    rd(REG_STATUS, 32'h0000_5282);
    rd(REG_CTRL, 32'h0000_001A);
    wr(REG_CTRL, 32'h3);
    rd(REG_CTRL, 32'h0000_001A);
    wr(REG_CTRL, 32'h0000_0004);
    rd(REG_CTRL, 32'h0000_0004);
    rd(8'h10, 32'h0);
    foreach (rows[i]) begin
      push(rows[i].b);
      check({25'h0, modeSymbol}, {25'h0, rows[i].s});
    end
    push(6'h10);
    host(F_ST);
    check({31'h0, busyReply}, 32'h1);
    push(6'h20);
    disp(5'h00, 6'h01, 7'h5A);
    push(6'h08);
    host(F_ST);
    check({31'h0, keyboardEnable}, 32'h0);
    host(F_ERR);
    check({31'h0, modeBlink}, 32'h1);
    disp(5'h00, 6'h00, SYM_RECV);
    check({31'h0, dispBlink}, 32'h1);
    host(F_ETX);
    hostMsg({5'h00, 6'h2C}, 25'h0C10000);
    check({31'h0, modeBlink}, 32'h0);
    disp(5'h00, 6'h2D, 7'h41);
    disp(5'h00, 6'h00, SYM_RECV);
    hostMsg({5'h01, 6'h00}, 25'h0);
    push(6'h01);
    rd(REG_POS, 32'h0001_0100);
    disp(5'h01, 6'h2F, SYM_ETX);
    disp(5'h00, 6'h2F, CODE_SP);
    repeat (46) push(6'h20);
    rd(REG_POS, 32'h0001_0200);
    hostMsg({5'h00, 6'h2D}, 25'h0C20000);
    hostMsg({5'h00, 6'h2C}, 25'h0);
    push(6'h04);
    check({25'h0, modeSymbol}, {25'h0, SYM_TX});
    check({31'h0, keyboardEnable}, 32'h0);
    waitTx(8'd50);
    check({4'h0, head}, {4'h0, 7'h41, 7'h42, CODE_CR, CODE_LF});
    rd(REG_POS, 32'h0001_0200);
    repeat (20) @(posedge clock);
    check({25'h0, modeSymbol}, {25'h0, SYM_TX});
    host(F_ACK);
    check({24'h0, modeSymbol, keyboardEnable}, {24'h0, SYM_RECV, 1'b1});
    hostMsg({5'h01, 6'h28}, 25'h0);
    push(6'h02);
    check({25'h0, modeSymbol}, {25'h0, SYM_PRINT});
    check({31'h0, txIsPrint}, 32'h1);
    waitTx(8'd56);
    push(6'h10);
    check({25'h0, modeSymbol}, {25'h0, SYM_LOCAL});
    host(F_NAK);
    repeat (30) @(posedge clock);
    check({24'h0, count}, 32'd56);
    host(F_ACK);
    check({24'h0, modeSymbol, keyboardEnable}, {24'h0, SYM_LOCAL, 1'b1});
    wr(REG_TIMEOUT, 32'h0000_0014);
    rd(REG_TIMEOUT, 32'h0000_0014);
    push(6'h04);
    waitTx(8'd62);
    repeat (30) @(posedge clock);
    check({24'h0, modeSymbol, keyboardEnable}, {24'h0, SYM_RECV, 1'b1});
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    #1;
    check({25'h0, modeSymbol}, {25'h0, SYM_RECV});
    wrapUp();
  end
endmodule
